// ===== rtl/fepp_pkg.sv
// Package of constants and types for the flash erase/program/protect sequencer
package fepp_pkg;
  // ********************************
  // Register map and fields
  // ********************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_ARRWR = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam int BIT_PGM_SEL = 0;
  localparam int BIT_ERS_SEL = 1;
  localparam int BIT_WHOLE = 2;
  localparam int BIT_HV = 3;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_READ_OK = 3;
  localparam int STAT_TEST_HV = 4;
  localparam int STAT_FLAG_LSB = 8;
  localparam int NUM_FLAGS = 7;
  localparam int FL_REFUSED = 0;
  localparam int FL_EARLY_HV = 1;
  localparam int FL_SHORT_RUN = 2;
  localparam int FL_SHORT_HOLD = 3;
  localparam int FL_PROG_FAST = 4;
  localparam int FL_PROG_SLOW = 5;
  localparam int FL_ROW_MISS = 6;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // ********************************
  // Memory layout
  // ********************************
  localparam logic [15:0] ARRAY_BASE = 16'hdc00;
  localparam logic [15:0] VEC_BASE = 16'hffdc;
  localparam logic [15:0] PROT_BYTE_ADDR = 16'hffd8;
  localparam logic [7:0] PB_ALL_MAX = 8'h70;
  localparam logic [7:0] PB_OPEN = 8'hff;
  localparam logic [1:0] PROT_TOP_BITS = 2'b11;
  // ********************************
  // Timing
  // ********************************
  localparam int CLK_MHZ = 50;
  localparam int T_NVS_NS = 10000;
  localparam int T_ERASE_NS = 4000000;
  localparam int T_NVH_NS = 5000;
  localparam int T_NVH1_NS = 100000;
  localparam int PUMP_SETTLE_WAIT_NS = 5000;
  localparam int T_PROG_NS = 30000;
  localparam int T_PROG_MAX_NS = 40000;
  localparam int T_RCV_NS = 1000;
  localparam int NVS_CYC = (T_NVS_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYC = (T_ERASE_NS * CLK_MHZ + 999) / 1000;
  localparam int NVH_CYC = (T_NVH_NS * CLK_MHZ + 999) / 1000;
  localparam int NVH1_CYC = (T_NVH1_NS * CLK_MHZ + 999) / 1000;
  localparam int PGS_CYC = (PUMP_SETTLE_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CYC = (T_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_MAX_CYC = (T_PROG_MAX_NS * CLK_MHZ) / 1000;
  localparam int RCV_CYC = (T_RCV_NS * CLK_MHZ + 999) / 1000;
  // ********************************
  // Types
  // ********************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEL = 3'b001,
    ST_ARMED = 3'b010,
    ST_LATCHED = 3'b011,
    ST_HV = 3'b100,
    ST_HOLD = 3'b101,
    ST_RECOVER = 3'b110
  } fepp_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic prog;
    logic erase_page;
    logic erase_all;
  } fepp_cmd_t;
endpackage

// ===== rtl/fepp_prot_check.sv
// Protected-region decoder for one target address
`timescale 1ns/100ps
module fepp_prot_check
  import fepp_pkg::*;
(
  input wire logic [7:0] prot_byte,
  input wire logic [15:0] addr,
  input wire logic whole,
  input wire logic test_hv,
  output logic prot
);
  // ********************************
  // Start address and region test
  // ********************************
  wire [15:0] start_addr = {PROT_TOP_BITS, prot_byte, 6'h00};
  wire open_all = (prot_byte == PB_OPEN);
  wire lock_all = (prot_byte <= PB_ALL_MAX) || (start_addr <= ARRAY_BASE);
  wire in_region = (addr >= start_addr) || (addr == PROT_BYTE_ADDR);
  // A whole-array erase touches the protected block, so any lock refuses it
  wire hit = whole ? 1'b1 : (lock_all || in_region);
  assign prot = !open_all && !test_hv && hit;
endmodule

// ===== rtl/fepp_top.sv
// Flash program/erase sequencer with block protection and APB registers
//
// Summary of operation
// - Erase page is 64 aligned bytes.
// - Vector page refuses page erase.
// - Reads resume after 1 us recovery.
// - Program row is 32 aligned bytes.
// - Program select enables address/data capture.
// - Protected region runs to top of memory.
// - Protected target blocks pump enable.
// - Protect byte gives address bits 13..6.
// - Values 00..70 protect whole array.
// - All ones leaves array open.
// - Programmed protect locks, test voltage overrides.
// - Pump only after selected setup sequence.
// - Program and erase select are interlocked.
// - Whole bit picks mass or page erase.
`timescale 1ns/100ps
module fepp_top
  import fepp_pkg::*;
#(
  parameter int CNT_W = 18,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int NVH1_CYCLES = NVH1_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] PROT_BYTE,
  input wire logic TEST_HV_PIN,
  output fepp_cmd_t ARR_CMD,
  output logic PUMP_EN,
  output logic READ_OK
);
  // Counter must hold the longest wait; a narrower one would saturate mid-erase
  if (CNT_W < 12 || CNT_W > 30 || ERASE_CYCLES < 1 || NVH1_CYCLES < 1 ||
      ERASE_CYCLES >= (1 << CNT_W) || NVH1_CYCLES >= (1 << CNT_W)) begin : g_bad_width
    $error("fepp_top: counter width cannot hold the wait counts");
  end
  // ********************************
  // APB decode
  // ********************************
  wire setup = PSEL && !PENABLE;
  wire access = PSEL && PENABLE;
  wire hit_ctrl = (PADDR == OFS_CTRL);
  wire hit_prot = (PADDR == OFS_PROT);
  wire hit_arr = (PADDR == OFS_ARRWR);
  wire hit_stat = (PADDR == OFS_STAT);
  wire mapped = hit_ctrl || hit_prot || hit_arr || hit_stat;
  wire wr_ctrl = access && PWRITE && hit_ctrl;
  wire wr_arr = access && PWRITE && hit_arr;
  wire wr_stat = access && PWRITE && hit_stat;
  wire rd_prot = access && !PWRITE && hit_prot;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;
  // ********************************
  // Test voltage synchroniser
  // ********************************
  logic thv_meta;
  logic thv;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      thv_meta <= 1'b0;
      thv <= 1'b0;
    end else begin
      thv_meta <= TEST_HV_PIN;
      thv <= thv_meta;
    end
  end
  // ********************************
  // Control bits and interlock
  // ********************************
  logic pgm_sel;
  logic ers_sel;
  logic whole;
  fepp_state_t state;
  wire hv_on = (state == ST_HV) || (state == ST_HOLD);
  wire w_pgm = PWDATA[BIT_PGM_SEL];
  wire w_ers = PWDATA[BIT_ERS_SEL];
  // A request setting both, or setting one while the other holds, is dropped
  wire next_pgm_sel = wr_ctrl ? (w_pgm && !w_ers && !ers_sel) : pgm_sel;
  wire next_ers_sel = wr_ctrl ? (w_ers && !w_pgm && !pgm_sel) : ers_sel;
  wire next_whole = wr_ctrl ? PWDATA[BIT_WHOLE] : whole;
  wire hv_set_req = wr_ctrl && PWDATA[BIT_HV] && !hv_on;
  wire hv_clr_req = wr_ctrl && !PWDATA[BIT_HV] && hv_on;
  wire sel_any = pgm_sel || ers_sel;
  wire next_sel_any = next_pgm_sel || next_ers_sel;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pgm_sel <= CTRL_RESET[BIT_PGM_SEL];
      ers_sel <= CTRL_RESET[BIT_ERS_SEL];
      whole <= CTRL_RESET[BIT_WHOLE];
    end else begin
      pgm_sel <= next_pgm_sel;
      ers_sel <= next_ers_sel;
      whole <= next_whole;
    end
  end
  // ********************************
  // Target capture and protection
  // ********************************
  logic [15:0] tgt_addr;
  logic tgt_prog;
  logic tgt_whole;
  logic tgt_prot;
  logic cmd_prot;
  wire [15:0] wr_addr = PWDATA[15:0];
  wire [7:0] wr_data = PWDATA[23:16];
  fepp_prot_check u_tgt_check (
    .prot_byte(PROT_BYTE),
    .addr(tgt_addr),
    .whole(tgt_whole),
    .test_hv(thv),
    .prot(tgt_prot)
  );
  fepp_prot_check u_cmd_check (
    .prot_byte(PROT_BYTE),
    .addr(wr_addr),
    .whole(1'b0),
    .test_hv(thv),
    .prot(cmd_prot)
  );
  wire tgt_vector = !tgt_prog && !tgt_whole && (tgt_addr >= VEC_BASE);
  wire same_row = (wr_addr[15:5] == tgt_addr[15:5]);
  // ********************************
  // Interval counter
  // ********************************
  logic [CNT_W-1:0] cnt;
  logic prog_seen;
  fepp_state_t next_state;
  wire prog_wr = (state == ST_HV) && tgt_prog && wr_arr;
  wire cnt_restart = (next_state != state) || prog_wr;
  wire cnt_full = &cnt;
  wire [CNT_W-1:0] cnt_inc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt <= '0;
    end else begin
      cnt <= cnt_restart ? '0 : (cnt_full ? cnt : cnt_inc);
    end
  end
  function automatic logic below(input logic [CNT_W-1:0] c, input int lim);
    below = ({{(32-CNT_W){1'b0}}, c} < lim[31:0]);
  endfunction
  // ********************************
  // Sequencer
  // ********************************
  wire hv_allowed = (state == ST_LATCHED) && !tgt_prot && !tgt_vector;
  wire hv_refused = hv_set_req && !hv_allowed;
  wire latch_ok = wr_arr && !(pgm_sel && cmd_prot && !whole);
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (next_sel_any) next_state = ST_SEL;
      end
      ST_SEL: begin
        if (!next_sel_any) next_state = ST_IDLE;
        else if (rd_prot) next_state = ST_ARMED;
      end
      ST_ARMED: begin
        if (!next_sel_any) next_state = ST_IDLE;
        else if (latch_ok) next_state = ST_LATCHED;
      end
      ST_LATCHED: begin
        if (!next_sel_any) next_state = ST_IDLE;
        else if (hv_set_req && hv_allowed) next_state = ST_HV;
      end
      ST_HV: begin
        if (hv_clr_req) next_state = ST_RECOVER;
        else if (!next_sel_any) next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (hv_clr_req) next_state = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (!below(cnt, RCV_CYC - 1)) next_state = sel_any ? ST_SEL : ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // Mode is frozen at capture so a later whole-bit flip cannot widen an erase
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tgt_addr <= 16'h0000;
      tgt_prog <= 1'b0;
      tgt_whole <= 1'b0;
    end else if (state == ST_ARMED && next_state == ST_LATCHED) begin
      tgt_addr <= wr_addr;
      tgt_prog <= pgm_sel;
      tgt_whole <= ers_sel && whole;
    end
  end
  // ********************************
  // Array commands
  // ********************************
  wire prog_early = prog_wr && (!prog_seen ? below(cnt, PGS_CYC) : below(cnt, PROG_CYC));
  wire prog_go = prog_wr && same_row && !cmd_prot && !prog_early;
  wire erasing = (state == ST_HV) && !tgt_prog;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ARR_CMD <= '0;
      PUMP_EN <= 1'b0;
      READ_OK <= 1'b1;
      prog_seen <= 1'b0;
    end else begin
      ARR_CMD.prog <= prog_go;
      ARR_CMD.erase_page <= erasing && !tgt_whole;
      ARR_CMD.erase_all <= erasing && tgt_whole;
      if (prog_go) begin
        ARR_CMD.addr <= wr_addr;
        ARR_CMD.data <= wr_data;
      end else if (erasing) begin
        ARR_CMD.addr <= {tgt_addr[15:6], 6'h00};
      end
      PUMP_EN <= (next_state == ST_HV) || (next_state == ST_HOLD);
      // Array reads stay fenced from pump on until recovery ends
      READ_OK <= (next_state != ST_HV) && (next_state != ST_HOLD) &&
                 (next_state != ST_RECOVER);
      if (state != ST_HV) prog_seen <= 1'b0;
      else if (prog_wr) prog_seen <= 1'b1;
    end
  end
  // ********************************
  // Timing checks and sticky flags
  // ********************************
  wire hold_min = tgt_whole ? below(cnt, NVH1_CYCLES) : below(cnt, NVH_CYC);
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_set;
  always_comb begin
    flag_set = '0;
    flag_set[FL_REFUSED] = hv_refused;
    flag_set[FL_EARLY_HV] = hv_set_req && hv_allowed && below(cnt, NVS_CYC);
    flag_set[FL_SHORT_RUN] = (state == ST_HV) && !tgt_prog && !next_sel_any &&
                             below(cnt, ERASE_CYCLES);
    flag_set[FL_SHORT_HOLD] = (state == ST_HOLD) && hv_clr_req && hold_min;
    flag_set[FL_PROG_FAST] = prog_early;
    flag_set[FL_PROG_SLOW] = (state == ST_HV) && tgt_prog && prog_seen &&
                             (cnt == PROG_MAX_CYC[CNT_W-1:0]);
    flag_set[FL_ROW_MISS] = prog_wr && (!same_row || cmd_prot);
  end
  wire [NUM_FLAGS-1:0] flag_clr = wr_stat ? PWDATA[STAT_FLAG_LSB +: NUM_FLAGS] : '0;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end
  // ********************************
  // Read data
  // ********************************
  wire [31:0] ctrl_word = {28'h0000000, hv_on, whole, ers_sel, pgm_sel};
  wire [31:0] stat_word = {{(24-NUM_FLAGS){1'b0}}, flags, 3'h0, thv, READ_OK, state};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_prot ? {24'h000000, PROT_BYTE} :
                       hit_stat ? stat_word : 32'h00000000;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h00000000;
    end else if (setup) begin
      PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
    end
  end
  // ********************************
  // Assertions
  // ********************************
  localparam int A_RCV = RCV_CYC;
  localparam int A_RCV1 = RCV_CYC + 1;
  // Remembers a program strobe in this pump-on span, so covers can see a second byte
  logic prog_pulsed;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prog_pulsed <= 1'b0;
    end else if (!PUMP_EN) begin
      prog_pulsed <= 1'b0;
    end else if (ARR_CMD.prog) begin
      prog_pulsed <= 1'b1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  a_select_interlock: assert property (!(pgm_sel && ers_sel))
    else $error("program and erase select both set");
  a_pump_after_setup: assert property ($rose(PUMP_EN) |-> $past(state) == ST_LATCHED &&
                                       sel_any)
    else $error("pump enabled outside the setup sequence");
  a_pump_protected: assert property ($rose(PUMP_EN) |-> !$past(tgt_prot))
    else $error("pump enabled on a protected target");
  a_vector_page: assert property (ARR_CMD.erase_page |-> ARR_CMD.addr < VEC_BASE)
    else $error("page erase issued on vector page");
  a_page_align: assert property (ARR_CMD.erase_page |-> ARR_CMD.addr[5:0] == 6'h00)
    else $error("page erase address not aligned");
  a_row_bound: assert property (ARR_CMD.prog |-> ARR_CMD.addr[15:5] == tgt_addr[15:5])
    else $error("program strobe outside latched row");
  a_recover_gap: assert property ($fell(PUMP_EN) |-> !READ_OK ##[A_RCV:A_RCV1] READ_OK)
    else $error("read recovery interval wrong");
  a_lock_all: assert property ((PROT_BYTE <= PB_ALL_MAX && !thv) |-> tgt_prot)
    else $error("low protect value left a target open");
  a_open_all: assert property ((PROT_BYTE == PB_OPEN) |-> !tgt_prot && !cmd_prot)
    else $error("open protect value blocked a target");
  a_refuse_flag: assert property (hv_refused |=> flags[FL_REFUSED] && !PUMP_EN)
    else $error("refused pump request not flagged");
  a_mass_mode: assert property ($rose(ARR_CMD.erase_all) |-> $past(tgt_whole, 2))
    else $error("whole-array erase without whole select");
  a_capture: assert property ((state == ST_ARMED && next_state == ST_LATCHED) |=>
                              tgt_addr == $past(wr_addr))
    else $error("target address not captured");
  c_page_erase: cover property ($rose(ARR_CMD.erase_page));
  c_mass_erase: cover property ($rose(ARR_CMD.erase_all));
  // Pump and read fence share one next-state decode, so they cannot drift apart
  a_read_fence: assert property (PUMP_EN |-> !READ_OK)
    else $error("array reads allowed while pump on");
  a_erase_one_kind: assert property (!(ARR_CMD.erase_page && ARR_CMD.erase_all))
    else $error("page and whole-array erase together");
  a_prog_pumped: assert property (ARR_CMD.prog |-> PUMP_EN)
    else $error("program strobe without pump on");
  c_row_prog: cover property (ARR_CMD.prog && prog_pulsed);
  c_refused: cover property (hv_refused);
  c_test_override: cover property (thv && PROT_BYTE != PB_OPEN && $rose(PUMP_EN));
endmodule

// ===== rtl/fepp_top_end.sv
// Holds no logic; the sequencer and its checks live in fepp_top

// ===== test/fepp_top_tb.sv
// Self-checking testbench for the flash program/erase sequencer
`timescale 1ns/100ps
module fepp_top_tb
  import fepp_pkg::*;
;
  // ********************************
  // Signals and device
  // ********************************
  // Short erase and mass hold keep the run small; expectations use these values
  localparam int ERS = 300;
  localparam int NVH1 = 100;
  logic sys_clk, rst_b, psel, penable, pwrite, test_hv_pin, err;
  logic [7:0] paddr, prot_byte;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, pump_en, read_ok;
  fepp_cmd_t arr_cmd, last_cmd;
  int fail_count, n_checks;
  int prog_cnt = 0;

  fepp_top #(.ERASE_CYCLES(ERS), .NVH1_CYCLES(NVH1)) dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PROT_BYTE(prot_byte),
    .TEST_HV_PIN(test_hv_pin), .ARR_CMD(arr_cmd), .PUMP_EN(pump_en), .READ_OK(read_ok)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Program strobe lasts one cycle, so it is caught at every edge
  always @(posedge sys_clk) begin
    if (arr_cmd.prog === 1'b1) begin
      prog_cnt <= prog_cnt + 1;
      last_cmd <= arr_cmd;
    end
  end

  // ********************************
  // Bus and compare tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One APB transfer; an idle edge after it keeps strobes from being driven twice
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    chk(n < 16, 1, "bus answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic arm(input logic [3:0] sel, input logic [15:0] a, input logic [7:0] pb,
                     input logic thv, input logic exp);
    prot_byte <= pb;
    test_hv_pin <= thv;
    wt(4);
    apb(OFS_CTRL, 1'b1, {28'h0, sel});
    apb(OFS_PROT, 1'b0, 32'h0);
    chk(rd[7:0], pb, "protect byte read");
    apb(OFS_ARRWR, 1'b1, {16'h0, a});
    wt(NVS_CYC + 5);
    apb(OFS_CTRL, 1'b1, {28'h0, sel | 4'h8});
    chk(pump_en, exp, "pump enable");
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(rd[STAT_FLAG_LSB + FL_REFUSED], !exp, "refused flag");
  endtask

  task automatic end_op(input int hold, input logic [3:0] keep);
    int n;
    apb(OFS_CTRL, 1'b1, {28'h0, keep});
    wt(hold);
    chk(arr_cmd[1:0], 2'b00, "erase level after deselect");
    apb(OFS_CTRL, 1'b1, 32'h0);
    chk({pump_en, read_ok}, 2'b00, "pump off, reads held");
    n = 0;
    while (read_ok !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n >= RCV_CYC - 2 && n <= RCV_CYC + 1, 1, "recovery length");
  endtask

  task automatic abort_op();
    apb(OFS_CTRL, 1'b1, 32'h0);
    wt(RCV_CYC + 5);
    chk(read_ok, 1, "reads allowed");
    apb(OFS_STAT, 1'b1, 32'h7f00);
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    chk({pump_en, read_ok}, 2'b01, "reset outputs");
    chk(arr_cmd, 0, "reset command");
    apb(OFS_CTRL, 1'b0, 32'h0);
    chk(rd, 0, "control reset");
    apb(8'h10, 1'b1, 32'h8);
    chk({err, pump_en}, 2'b10, "unmapped write");
    $display("test reset done");
  endtask

  task automatic t_interlock();
    apb(OFS_CTRL, 1'b1, 32'h3);
    apb(OFS_CTRL, 1'b0, 32'h0);
    chk(rd[2:0], 3'b000, "both selects at once");
    apb(OFS_CTRL, 1'b1, 32'h1);
    apb(OFS_CTRL, 1'b1, 32'h7);
    apb(OFS_CTRL, 1'b0, 32'h0);
    chk(rd[2:0], 3'b100, "erase while program");
    apb(OFS_CTRL, 1'b1, 32'h0);
    apb(OFS_CTRL, 1'b1, 32'h2);
    apb(OFS_CTRL, 1'b1, 32'h3);
    apb(OFS_CTRL, 1'b0, 32'h0);
    chk(rd[2:0], 3'b000, "program while erase");
    apb(OFS_CTRL, 1'b1, 32'h0);
    apb(OFS_CTRL, 1'b1, 32'h8);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk({pump_en, rd[STAT_FLAG_LSB + FL_REFUSED]}, 2'b01, "pump from idle");
    apb(OFS_STAT, 1'b1, 32'h7f00);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(rd[14:8], 0, "flags cleared");
    $display("test interlock done");
  endtask

  task automatic t_erase(input logic mass, input logic [15:0] a, input logic [15:0] base);
    arm(mass ? 4'h6 : 4'h2, a, 8'hff, 1'b0, 1'b1);
    wt(2);
    chk(arr_cmd[1:0], mass ? 2'b01 : 2'b10, "erase kind");
    chk(arr_cmd.addr, base, "erase page base");
    wt(ERS + 5);
    end_op(mass ? NVH1 + 5 : NVH_CYC + 5, mass ? 4'hc : 4'h8);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(rd[14:8], 0, "no timing flags");
    arm(4'h2, 16'hffe0, 8'hff, 1'b0, 1'b0);
    abort_op();
    $display("test erase done");
  endtask

  task automatic t_program();
    int p0;
    arm(4'h1, 16'hdc25, 8'hff, 1'b0, 1'b1);
    wt(PGS_CYC + 5);
    p0 = prog_cnt;
    apb(OFS_ARRWR, 1'b1, 32'h005adc21);
    apb(OFS_ARRWR, 1'b1, 32'h0033dc22);
    wt(2);
    chk(prog_cnt - p0, 1, "early write dropped");
    chk({last_cmd.addr, last_cmd.data}, 24'hdc215a, "captured byte");
    wt(PROG_CYC + 5);
    apb(OFS_ARRWR, 1'b1, 32'h0066dc23);
    wt(PROG_CYC + 5);
    chk({last_cmd.addr, last_cmd.data}, 24'hdc2366, "second row byte");
    apb(OFS_ARRWR, 1'b1, 32'h0044dc40);
    wt(PROG_MAX_CYC);
    chk(prog_cnt - p0, 2, "write outside row");
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(rd[14:8], 7'h70, "program flags");
    end_op(NVH_CYC + 5, 4'h8);
    apb(OFS_STAT, 1'b1, 32'h7f00);
    $display("test program done");
  endtask

  task automatic t_protect();
    logic [7:0] pb [8] = '{8'h71, 8'h71, 8'h50, 8'h70, 8'hfe, 8'hfe, 8'h71, 8'hff};
    logic [15:0] ad [8] = '{16'hdc40, 16'hdc00, 16'hfb00, 16'hfb00, 16'hff80, 16'hff40,
                            16'hdc40, 16'hfbe0};
    logic [7:0] thv = 8'b0100_0000;
    logic [7:0] ex = 8'b1110_0010;
    for (int i = 0; i < 8; i++) begin
      arm(4'h1, ad[i], pb[i], thv[i], ex[i]);
      abort_op();
    end
    $display("test protect done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ********************************
  // Main sequence and watchdog
  // ********************************
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    prot_byte = 8'hff;
    test_hv_pin = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_interlock();
    t_erase(1'b0, 16'hdc47, 16'hdc40);
    t_erase(1'b1, 16'hdc00, 16'hdc00);
    t_program();
    t_protect();
    print_verdict();
  end

  // All scenarios need about 14200 cycles; the limit leaves ample margin
  initial begin
    #(40000 * 20);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule
